//--- design/return_address_stack.sv
// four-level return-address stack with pointer and interrupt enable register
`timescale 1ns/1ps
module return_address_stack
  import ras_pkg::*;
(
  input  wire logic            i_clk,              // core instruction clock
  input  wire logic            i_rstn,             // system reset, active low
  input  wire logic            i_ce,               // clock enable, freezes state
  input  wire logic            i_push,             // call or interrupt entry
  input  wire logic            i_pop_sub,          // return from subroutine
  input  wire logic            i_pop_irq,          // return from interrupt
  input  wire logic [PC_W-1:0] i_pc,               // program counter to save
  input  wire logic [7:0]      i_reg_addr,         // bank 0 system register address
  input  wire logic            i_reg_wr,           // register write strobe
  input  wire logic            i_reg_rd,           // register read strobe
  input  wire logic [7:0]      i_reg_wdata,        // register write data
  output logic      [7:0]      o_reg_rdata,        // register read data
  output logic                 o_reg_rvalid,       // read data valid pulse
  output logic      [PC_W-1:0] o_pc_restore,       // restored program counter
  output logic                 o_restore_valid,    // restore valid pulse
  output logic                 o_restore_from_irq, // restore was an irq return
  output logic      [PTR_W-1:0] o_stack_ptr,       // current pointer
  output logic                 o_global_irq_enable, // interrupt enable bit
  output logic                 o_stack_overflow    // pointer below full level
);
  logic             rst_meta_ff;
  logic             rst_sync_ff;
  logic [PTR_W-1:0] ptr_ff;
  logic [PTR_W-1:0] nxt_ptr;
  logic             irq_en_ff;
  logic             nxt_irq_en;
  logic             ovf_ff;
  logic             rd_ptr_ff;
  logic             rd_stk_ff;
  logic             rd_hi_ff;
  logic             rd_val_ff;
  logic [7:0]       ptr_snap_ff;
  logic [7:0]       rdata_ff;
  logic             rvalid_ff;
  logic             rst_valid_ff;
  logic             rst_irq_ff;
  logic [PC_W-1:0]  mem_a;
  logic [PC_W-1:0]  mem_b;

  ////////////////////////////////////////////////////////////////////////////
  // reset release; not gated by clock enable so release always completes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire             pop        = i_pop_sub | i_pop_irq;
  wire             do_push    = i_push;
  wire             do_pop     = pop & ~i_push;
  wire             is_ptr     = (i_reg_addr == PTR_ADDR);
  wire             is_stk     = (i_reg_addr[7:3] == STK_ADDR_TAG);
  wire             stk_hi     = i_reg_addr[0];
  wire [IDX_W-1:0] stk_idx    = i_reg_addr[2:1];
  wire             ptr_wr     = i_reg_wr & is_ptr;
  // entries fill 0..3 as the pointer walks 111 down to 011
  wire [IDX_W-1:0] push_idx   = ~ptr_ff[IDX_W-1:0];
  wire             push_ok    = do_push & ptr_ff[PTR_W-1];
  wire [PTR_W-1:0] ptr_up     = ptr_ff + 3'h1;
  wire [PTR_W-1:0] ptr_dn     = ptr_ff - 3'h1;
  wire [IDX_W-1:0] pop_idx    = ~ptr_up[IDX_W-1:0];
  // a push with pointer bit 2 set owns the single write port; a register write that cycle is lost
  wire             stk_wr     = i_reg_wr & is_stk & ~push_ok;
  wire             we_hi      = push_ok | (stk_wr & stk_hi);
  wire             we_lo      = push_ok | (stk_wr & ~stk_hi);
  wire [IDX_W-1:0] waddr      = push_ok ? push_idx : stk_idx;
  wire [PC_W-1:0]  wdata      = push_ok ? i_pc : {i_reg_wdata[PC_HI_W-1:0], i_reg_wdata};
  wire [7:0]       ptr_view   = {irq_en_ff, 4'h0, ptr_ff};
  wire [7:0]       stk_view   = rd_hi_ff ? {6'h00, mem_b[PC_W-1:PC_W-PC_HI_W]}
                                         : mem_b[PC_W-PC_HI_W-1:0];
  wire [7:0]       rdata_sel  = rd_stk_ff ? stk_view : (rd_ptr_ff ? ptr_snap_ff : 8'h00);
  wire             ovf_next   = ~nxt_ptr[PTR_W-1] & (nxt_ptr != PTR_FULL);

  ////////////////////////////////////////////////////////////////////////////
  // hardware stack motion takes priority over a software pointer write
  always_comb begin
    nxt_ptr = ptr_ff;
    nxt_irq_en = irq_en_ff;
    if (ptr_wr) begin
      nxt_irq_en = i_reg_wdata[IRQ_EN_BIT];
    end
    if (do_push) begin
      nxt_ptr = ptr_dn;
    end else if (do_pop) begin
      nxt_ptr = ptr_up;
    end else if (ptr_wr) begin
      nxt_ptr = i_reg_wdata[PTR_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ptr_ff <= PTR_RESET;
      irq_en_ff <= IRQ_EN_RESET;
      ovf_ff <= 1'b0;
    end else if (i_ce) begin
      ptr_ff <= nxt_ptr;
      irq_en_ff <= nxt_irq_en;
      ovf_ff <= ovf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads answer two edges later: one for the memory's read latency, one for the output register
  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rd_ptr_ff    <= 1'b0;
      rd_stk_ff    <= 1'b0;
      rd_hi_ff     <= 1'b0;
      rd_val_ff    <= 1'b0;
      ptr_snap_ff  <= RDATA_RESET;
      rdata_ff     <= RDATA_RESET;
      rvalid_ff    <= 1'b0;
    end else if (i_ce) begin
      rd_ptr_ff    <= i_reg_rd & is_ptr;
      rd_stk_ff    <= i_reg_rd & is_stk;
      rd_hi_ff     <= stk_hi;
      rd_val_ff    <= i_reg_rd;
      ptr_snap_ff  <= ptr_view;
      rdata_ff     <= rdata_sel;
      rvalid_ff    <= rd_val_ff;
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rst_valid_ff <= 1'b0;
      rst_irq_ff   <= 1'b0;
    end else if (i_ce) begin
      rst_valid_ff <= do_pop;
      rst_irq_ff   <= do_pop & i_pop_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  stack_mem u_mem (
    .i_clk     (i_clk),
    .i_rstn    (rst_sync_ff),
    .i_ce      (i_ce),
    .i_we_hi   (we_hi),
    .i_we_lo   (we_lo),
    .i_waddr   (waddr),
    .i_wdata   (wdata),
    .i_raddr_a (pop_idx),
    .i_raddr_b (stk_idx),
    .o_rdata_a (mem_a),
    .o_rdata_b (mem_b)
  );

  assign o_reg_rdata         = rdata_ff;
  assign o_reg_rvalid        = rvalid_ff;
  assign o_pc_restore        = mem_a;
  assign o_restore_valid     = rst_valid_ff;
  assign o_restore_from_irq  = rst_irq_ff;
  assign o_stack_ptr         = ptr_ff;
  assign o_global_irq_enable = irq_en_ff;
  assign o_stack_overflow    = ovf_ff;
endmodule // return_address_stack

//--- design/ras_pkg.sv
// constants shared by the return-address stack and its entry memory
//
// Overview of operation
// - exactly four entries hold saved program counters
// - three-bit pointer resets to 111, meaning empty
// - entry is 10 bits, high and low registers
// - push decrements pointer, pop increments it
// - call or interrupt entry pushes the PC
// - pops return entries last in, first out
// - pointer at 0DFH, entries in bank 0
// - pointer bit 7 is global interrupt enable
// - pushes fill entries 0..3; fifth push overflows
// - both return kinds pop and restore the PC
// - pop increments pointer, loads saved value out
// - entries reset to 0; upper high bits unimplemented
// - program counter is 10 bits, 2 high plus 8 low
package ras_pkg;
  localparam int          PC_W          = 10;
  localparam int          PC_HI_W       = 2;
  localparam int          DEPTH         = 4;
  localparam int          IDX_W         = 2;
  localparam int          PTR_W         = 3;
  localparam int          IRQ_EN_BIT    = 7;
  localparam logic [7:0]  PTR_ADDR      = 8'hDF;
  localparam logic [4:0]  STK_ADDR_TAG  = 5'h1F;
  localparam logic [2:0]  PTR_RESET     = 3'h7;
  localparam logic [2:0]  PTR_FULL      = 3'h3;
  localparam logic        IRQ_EN_RESET  = 1'b0;
  localparam logic [9:0]  PC_RESET      = 10'h000;
  localparam logic [7:0]  RDATA_RESET   = 8'h00;
endpackage

//--- design/stack_mem.sv
// four-entry storage for saved program counters, registered read ports
`timescale 1ns/1ps
module stack_mem
  import ras_pkg::*;
(
  input  wire logic             i_clk,     // core clock
  input  wire logic             i_rstn,    // synchronised reset, active low
  input  wire logic             i_ce,      // clock enable
  input  wire logic             i_we_hi,   // write bits 9:8
  input  wire logic             i_we_lo,   // write bits 7:0
  input  wire logic [IDX_W-1:0] i_waddr,   // write entry
  input  wire logic [PC_W-1:0]  i_wdata,   // write data
  input  wire logic [IDX_W-1:0] i_raddr_a, // pop read entry
  input  wire logic [IDX_W-1:0] i_raddr_b, // register read entry
  output logic      [PC_W-1:0]  o_rdata_a, // pop read data, registered
  output logic      [PC_W-1:0]  o_rdata_b  // register read data, registered
);
  logic [PC_W-1:0] entry_ff [DEPTH];
  logic [PC_W-1:0] rdata_a_ff;
  logic [PC_W-1:0] rdata_b_ff;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          entry_ff[g] <= PC_RESET;
        end else if (i_ce && i_waddr == IDX_W'(g)) begin
          if (i_we_hi) begin
            entry_ff[g][PC_W-1:PC_W-PC_HI_W] <= i_wdata[PC_W-1:PC_W-PC_HI_W];
          end
          if (i_we_lo) begin
            entry_ff[g][PC_W-PC_HI_W-1:0] <= i_wdata[PC_W-PC_HI_W-1:0];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_a_ff <= PC_RESET;
      rdata_b_ff <= PC_RESET;
    end else if (i_ce) begin
      rdata_a_ff <= entry_ff[i_raddr_a];
      rdata_b_ff <= entry_ff[i_raddr_b];
    end
  end

  assign o_rdata_a = rdata_a_ff;
  assign o_rdata_b = rdata_b_ff;
endmodule // stack_mem

//--- verif/ras_sva.sv
// port assertions for the return-address stack
`timescale 1ns/1ps
module ras_sva
  import ras_pkg::*;
(
  input wire logic            i_clk,              // clock
  input wire logic            i_rstn,             // reset
  input wire logic            i_ce,               // enable
  input wire logic            i_push,             // call
  input wire logic            i_pop_sub,          // subroutine return
  input wire logic            i_pop_irq,          // interrupt return
  input wire logic [PC_W-1:0] i_pc,               // pc in
  input wire logic            i_reg_rd,           // read
  input wire logic            o_reg_rvalid,       // read valid
  input wire logic [PC_W-1:0] o_pc_restore,       // pc out
  input wire logic            o_restore_valid,    // pc valid
  input wire logic            o_restore_from_irq, // irq kind
  input wire logic [2:0]      o_stack_ptr,        // pointer
  input wire logic            o_stack_overflow    // overflow
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire pop_take = i_ce && !i_push && (i_pop_sub || i_pop_irq);
  a_push_down: assert property (i_ce && i_push |=> o_stack_ptr == $past(o_stack_ptr) - 3'h1)
    else $error("push step");
  a_pop_up: assert property (pop_take |=> o_stack_ptr == $past(o_stack_ptr) + 3'h1)
    else $error("pop step");
  a_restore_pulse: assert property (pop_take |=> o_restore_valid)
    else $error("no restore");
  a_restore_quiet: assert property (i_ce && !pop_take |=> !o_restore_valid)
    else $error("stray restore");
  a_irq_kind: assert property (pop_take |=> o_restore_from_irq == $past(i_pop_irq))
    else $error("restore kind");
  a_ce_hold: assert property (!i_ce |=> o_stack_ptr == $past(o_stack_ptr))
    else $error("pointer moved while frozen");
  a_over_level: assert property (o_stack_overflow == (!o_stack_ptr[2] && o_stack_ptr != 3'h3))
    else $error("overflow flag");
  a_lifo_back: assert property (i_ce && i_push && o_stack_ptr[2] ##1 pop_take
    |=> o_pc_restore == $past(i_pc, 2)) else $error("lifo value");
  a_read_lat: assert property (i_ce && i_reg_rd ##1 i_ce |=> o_reg_rvalid)
    else $error("read latency");
  c_full: cover property (i_push && o_stack_ptr == PTR_FULL);
  c_irq_ret: cover property (o_restore_valid && o_restore_from_irq);
  c_read: cover property (o_reg_rvalid);
endmodule // ras_sva
bind return_address_stack ras_sva i_sva (.*);

//--- verif/core_seq_model.sv
// sequencer stand-in issuing calls and returns
`timescale 1ns/1ps
module core_seq_model
  import ras_pkg::*;
(
  input  wire logic            i_clk,     // clock
  input  wire logic [2:0]      i_cmd,     // 0 idle 1 call 2 sub pop 3 irq pop 4 random
  output logic                 o_push,    // call
  output logic                 o_pop_sub, // subroutine return
  output logic                 o_pop_irq, // interrupt return
  output logic      [PC_W-1:0] o_pc       // pc to save
);
  integer     seed = 25335;
  logic [2:0] op;
  initial {o_push, o_pop_sub, o_pop_irq, o_pc} = '0;
  always @(posedge i_clk) begin
    op = (i_cmd == 3'h4) ? 3'($unsigned($random(seed)) % 4) : i_cmd;
    o_push    <= (op == 3'h1);
    o_pop_sub <= (op == 3'h2);
    o_pop_irq <= (op == 3'h3);
    // pc line is not held between calls
    o_pc      <= (op == 3'h1) ? 10'($random(seed)) : ~o_pc;
  end
endmodule // core_seq_model

//--- verif/return_address_stack_test.sv
// self-checking bench for the return-address stack
`timescale 1ns/1ps
module return_address_stack_test import ras_pkg::*;;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, ce = 1, push, pops, popi, rv, vld, irq, ien, ovf;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [PC_W-1:0] pc, rpc, m_pc = '0;
  logic [2:0] cmd = 3'h0, sp, m_sp = 3'h7;
  logic m_ien = 0, m_v = 0, m_irq = 0;
  logic [PC_W-1:0] m_mem [DEPTH] = '{default: '0};
  int n_errors = 0, n_checks = 0;
  int seed = 25335;
  initial forever #12.5 clk = ~clk;
  return_address_stack i_dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_push(push),
    .i_pop_sub(pops), .i_pop_irq(popi), .i_pc(pc), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rv),
    .o_pc_restore(rpc), .o_restore_valid(vld), .o_restore_from_irq(irq),
    .o_stack_ptr(sp), .o_global_irq_enable(ien), .o_stack_overflow(ovf));
  core_seq_model i_seq (.i_clk(clk), .i_cmd(cmd),
    .o_push(push), .o_pop_sub(pops), .o_pop_irq(popi), .o_pc(pc));
  ////////////////////////////////////////////////////////////////////////////////
  // reference model; bench never writes the pointer during stack motion
  always @(posedge clk) if (rstn && ce) begin
    m_v = 0;
    if (wr && addr >= 8'hF8 && !(push && m_sp[2])) begin
      if (addr[0]) m_mem[addr[2:1]][9:8] = wdata[1:0];
      else m_mem[addr[2:1]][7:0] = wdata;
    end
    if (wr && addr == PTR_ADDR) {m_ien, m_sp} = {wdata[7], wdata[2:0]};
    if (push) begin
      if (m_sp[2]) m_mem[~m_sp[1:0]] = pc;
      m_sp = m_sp - 3'h1;
    end else if (pops || popi) begin
      m_sp = m_sp + 3'h1;
      {m_v, m_irq, m_pc} = {1'b1, popi, m_mem[~m_sp[1:0]]};
    end
  end
  always @(negedge clk) if (rstn) begin
    check("pointer", sp, m_sp);
    check("overflow", ovf, !m_sp[2] && m_sp != 3'h3);
    check("irq enable", ien, m_ien);
    check("restore valid", vld, m_v);
    if (m_v) check("restore pc", {irq, rpc}, {m_irq, m_pc});
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [10:0] seen, logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    // answer stands in the cycle after the second edge from the take
    @(posedge clk);
    @(negedge clk) check("read valid", rv, 1'b1);
    check("read data", rdata, exp);
  endtask
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic run(logic [2:0] c, int n);
    @(posedge clk) cmd <= c;
    repeat (n) @(posedge clk);
    cmd <= 3'h0;
    repeat (2) @(posedge clk);
  endtask
  // random stack traffic with the clock enable dropping at random
  task automatic run_gated(int n);
    @(posedge clk) cmd <= 3'h4;
    repeat (n) @(posedge clk) ce <= 1'($random(seed));
    @(posedge clk) {cmd, ce} <= {3'h0, 1'b1};
    repeat (2) @(posedge clk);
  endtask
  task automatic read_entries();
    for (int a = 8'hF8; a <= 8'hFF; a++)
      reg_rd(8'(a), a[0] ? {6'h00, m_mem[a[2:1]][9:8]} : m_mem[a[2:1]][7:0]);
  endtask
  task automatic test_done();
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    reg_rd(PTR_ADDR, 8'h07);
    read_entries();
    reg_wr(PTR_ADDR, 8'h07);
    run(3'h1, 5);
    read_entries();
    run(3'h3, 2);
    run(3'h2, 3);
    reg_wr(PTR_ADDR, 8'h85);
    reg_wr(8'hFA, 8'h5C);
    run(3'h2, 1);
    reg_rd(PTR_ADDR, 8'h86);
    reg_rd(8'h80, 8'h00);
    run(3'h4, 300);
    run_gated(200);
    read_entries();
    test_done();
  end
endmodule // return_address_stack_test
